// >>> verif/cosd_clock_receiver_model.sv
module cosd_clock_receiver_model (
    input  wire logic        i_clk,
    input  wire logic [7:0]  i_pins,
    output logic      [31:0] o_high_cyc [8],
    output logic      [31:0] o_low_cyc [8]
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0]  prev;
    logic [31:0] cnt [8];

    // receiver measures each level in clock cycles; no reset, like a real input
    always_ff @(posedge i_clk) begin
        prev <= i_pins;
        for (int p = 0; p < 8; p++) begin
            if (i_pins[p] !== prev[p]) begin
                cnt[p] <= 32'h0000_0001;
                if (i_pins[p]) o_low_cyc[p] <= cnt[p];
                else o_high_cyc[p] <= cnt[p];
            end else begin
                cnt[p] <= cnt[p] + 32'h0000_0001;
            end
        end
    end
endmodule // cosd_clock_receiver_model

// >>> verif/cosd_output_stage_assertions.sv
module cosd_output_stage_assertions (
    input wire logic                           i_clk,
    input wire logic                           i_arst_n,
    input wire logic [cosd_pkg::NUM_FRAC-1:0]  i_frac_divider_tick,
    input wire logic                           i_psel,
    input wire logic                           i_penable,
    input wire logic                           i_pwrite,
    input wire logic [11:0]                    i_paddr,
    input wire logic [31:0]                    i_pwdata,
    input wire logic [31:0]                    o_prdata,
    input wire logic                           o_pready,
    input wire logic                           o_pslverr,
    input wire logic [cosd_pkg::NUM_PATHS-1:0] o_true_output_pin,
    input wire logic [cosd_pkg::NUM_PATHS-1:0] o_complementary_output_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);

    // access phase seen by every check below except the stage source checks; hole decode only by the two hole checks
    logic acc;
    logic hole;
    assign acc  = i_psel && i_penable;
    assign hole = (i_paddr >= 12'h080 && i_paddr < 12'h100) || i_paddr >= 12'h104;

    ready_in_access_a: assert property (acc |-> o_pready)
        else $error("pready low in access");
    stage_four_src_a: assert property ($changed(o_true_output_pin[1:0])
        |-> $past(i_frac_divider_tick[0] || i_frac_divider_tick[1])) else $error("stage 4 edge");
    stage_five_src_a: assert property ($changed(o_true_output_pin[3:2])
        |-> $past(i_frac_divider_tick[1])) else $error("stage 5 edge");
    stage_six_src_a: assert property ($changed(o_true_output_pin[5:4])
        |-> $past(i_frac_divider_tick[2])) else $error("stage 6 edge");
    stage_seven_src_a: assert property ($changed(o_true_output_pin[7:6])
        |-> $past(i_frac_divider_tick[2] || i_frac_divider_tick[3])) else $error("stage 7 edge");
    hole_err_a: assert property (acc && hole |-> o_pslverr)
        else $error("no error on unmapped access");
    mapped_ok_a: assert property (acc && i_paddr < 12'h080 && i_paddr[1:0] == 2'b00 |-> !o_pslverr)
        else $error("error on mapped access");
    hole_zero_a: assert property (acc && !i_pwrite && hole |-> o_prdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    // a falling true pin is never a period start, so the pair must move together
    // an invert write two edges back may legally hold the complementary pin
    comp_tracks_a: assert property (!$past(acc && i_pwrite, 2) |->
        (~o_true_output_pin & $past(o_true_output_pin) &
        ~(o_complementary_output_pin ^ $past(o_complementary_output_pin))) == 8'h00)
        else $error("complementary pin did not follow");
endmodule // cosd_output_stage_assertions

// >>> verif/cosd_output_stage_tb.sv
module cosd_output_stage_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_clk = 1'b0, i_arst_n = 1'b0, i_psel = 1'b0, i_penable = 1'b0;
    logic        i_pwrite = 1'b0, o_pready, o_pslverr, e;
    logic [3:0]  i_frac_divider_tick = 4'h0;
    logic [11:0] i_paddr = 12'h000;
    logic [31:0] i_pwdata = 32'h0000_0000, o_prdata, q;
    logic [7:0]  o_true_output_pin, o_complementary_output_pin;
    logic [31:0] high_cyc [8], low_cyc [8];
    logic [7:0]  div_cnt [4] = '{default: 8'h00};
    int          num_errors = 0, samples_checked = 0;

    always #2 i_clk = ~i_clk;
    // source n ticks every n+3 cycles, so the measured length names the source
    always_ff @(posedge i_clk) begin
        for (int n = 0; n < 4; n++) begin
            div_cnt[n] <= (div_cnt[n] == 8'(n + 2)) ? 8'h00 : div_cnt[n] + 8'h01;
            i_frac_divider_tick[n] <= (div_cnt[n] == 8'(n + 2));
        end
    end

    cosd_output_stage i_dut (.i_clk(i_clk), .i_arst_n(i_arst_n),
        .i_frac_divider_tick(i_frac_divider_tick), .i_psel(i_psel), .i_penable(i_penable),
        .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
        .o_pready(o_pready), .o_pslverr(o_pslverr), .o_true_output_pin(o_true_output_pin),
        .o_complementary_output_pin(o_complementary_output_pin));
    cosd_clock_receiver_model i_rx (.i_clk(i_clk), .i_pins(o_true_output_pin),
        .o_high_cyc(high_cyc), .o_low_cyc(low_cyc));

    task automatic stop_test();
        if (num_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        samples_checked++;
        if (g !== x) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", n, x, g);
        end
    endtask

    // one apb transfer; held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge i_clk);
        {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} <= {1'b1, 1'b0, wr, a, d};
        @(posedge i_clk);
        i_penable <= 1'b1;
        do @(posedge i_clk); while (o_pready !== 1'b1);
        q = o_prdata;
        e = o_pslverr;
        {i_psel, i_penable} <= 2'b00;
    endtask

    // bounded wait for the next rise, then two more edges so the model catches it
    task automatic wait_rise(input int p);
        int k;
        k = 0;
        while (o_true_output_pin[p] !== 1'b0 && k < 3000) begin @(negedge i_clk); k++; end
        while (o_true_output_pin[p] !== 1'b1 && k < 3000) begin @(negedge i_clk); k++; end
        repeat (2) @(negedge i_clk);
    endtask

    // a shortened half stops at two ticks, or stays put if already below two
    function automatic int clamp(input int b, input int d);
        return (d < 0 && b + d < 2) ? ((b < 2) ? b : 2) : b + d;
    endfunction

    initial begin
        repeat (90000) @(posedge i_clk);
        num_errors++;
        stop_test();
    end

    initial begin
        int r, w, s, p, hb, hd, sel, inv, k, n;
        logic [11:0] b;
        void'($urandom(12228));
        repeat (2) @(posedge i_clk);
        i_arst_n <= 1'b1;
        for (p = 0; p < 8; p++) begin
            apb(1'b0, 12'(p) * cosd_pkg::PATH_STRIDE + cosd_pkg::OFF_RATIO, 32'h0000_0000);
            chk("ratio reset", cosd_pkg::RATIO_RST, q);
            apb(1'b0, 12'(p) * cosd_pkg::PATH_STRIDE + cosd_pkg::OFF_HIGH, 32'h0000_0000);
            chk("high reset", cosd_pkg::HIGH_RST, q);
        end
        apb(1'b0, 12'h200, 32'h0000_0000);
        chk("hole read", 32'h0000_0000, q);
        chk("hole error", 32'h0000_0001, {31'h0, e});
        // random configs, every path twice so steps repeat; last one clamps hard
        for (int t = 0; t < 16; t++) begin
            p = t % 8;
            b = 12'(p) * cosd_pkg::PATH_STRIDE;
            r = 5 + $urandom % 8;
            w = (t % 3 == 0) ? 0 : 1 + $urandom % (r - 1);
            sel = $urandom % 4;
            inv = $urandom % 2;
            s = (t == 15) ? -100 : int'($urandom % 9) - 4;
            apb(1'b1, cosd_pkg::OFF_SRC_SEL, 32'(sel));
            apb(1'b1, b + cosd_pkg::OFF_RATIO, 32'(r));
            apb(1'b1, b + cosd_pkg::OFF_HIGH, 32'(w));
            apb(1'b1, b + cosd_pkg::OFF_CTRL, 32'(inv));
            repeat (3) wait_rise(p);
            k = 3 + ((p < 2) ? (sel & 1) : (p < 6) ? p / 2 : 2 + ((sel >> 1) & 1));
            hb = (w == 0) ? (r + 1) / 2 : w;
            chk("high time", 32'(hb * k), high_cyc[p]);
            chk("low time", 32'((r - hb) * k), low_cyc[p]);
            chk("comp pin", {31'h0, o_true_output_pin[p] ^ 1'(inv)},
                {31'h0, o_complementary_output_pin[p]});
            apb(1'b1, b + cosd_pkg::OFF_PHASE, 32'(s));
            n = 0;
            do begin apb(1'b0, b + cosd_pkg::OFF_CTRL, 32'h0000_0000); n++; end
            while (q[cosd_pkg::CTRL_PENDING] === 1'b1 && n < 200);
            wait_rise(p);
            hd = (w == 0) ? (s >>> 1) : 0;
            chk("step high", 32'(clamp(hb, hd) * k), high_cyc[p]);
            chk("step low", 32'(clamp(r - hb, s - hd) * k), low_cyc[p]);
        end
        stop_test();
    end
endmodule // cosd_output_stage_tb

bind cosd_output_stage cosd_output_stage_assertions i_chk (.i_clk(i_clk), .i_arst_n(i_arst_n),
    .i_frac_divider_tick(i_frac_divider_tick), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .o_true_output_pin(o_true_output_pin),
    .o_complementary_output_pin(o_complementary_output_pin));

// >>> verilog/cosd_output_stage.sv
// Notes on behaviour
// - stage 4 picks divider 4 or 5, stage 7 divider 6 or 7; 5,6 fixed.
// - every stage has two identical paths on the same source divider.
// - each path divides source ticks by a 32-bit unsigned ratio.
// - default output is 50/50, halves taken from the ratio.
// - pulse mode holds high for high_pulse_width ticks, low for the rest.
// - duty cycle controls apply in every mode of the stage.
// - duty cycle pulses are always active high on the true pin.
// - invert option makes the complementary pin an inverted copy.
// - each path has its own coarse step in whole source periods.
// - positive step lengthens the period, negative step shortens it.
// - shortening never goes below 2 ticks high plus 2 ticks low; the code keeps a half that is already below 2 ticks at its own length.
// - one step changes a period by at most 2^31 ticks, high and low together.
// - the whole step lands within one output period.
// - in 50/50 mode the step splits evenly between high and low.
// - in pulse mode the step alters only the low time.
// - any number of successive steps is accepted.
//
// Our own choices: the register addresses and the APB slave port.
module cosd_output_stage (
    input  wire logic                                    i_clk,
    input  wire logic                                    i_arst_n,
    input  wire logic [cosd_pkg::NUM_FRAC-1:0]           i_frac_divider_tick,
    input  wire logic                                    i_psel,
    input  wire logic                                    i_penable,
    input  wire logic                                    i_pwrite,
    input  wire logic [11:0]                             i_paddr,
    input  wire logic [31:0]                             i_pwdata,
    output logic      [31:0]                             o_prdata,
    output logic                                         o_pready,
    output logic                                         o_pslverr,
    output logic      [cosd_pkg::NUM_PATHS-1:0]          o_true_output_pin,
    output logic      [cosd_pkg::NUM_PATHS-1:0]          o_complementary_output_pin
);

    localparam int unsigned NP = cosd_pkg::NUM_PATHS;
    localparam int unsigned LW = cosd_pkg::LEN_W;

    // apb decode
    logic              setup_phase;
    logic              write_now;
    logic              in_paths;
    logic [2:0]        dec_path;
    logic [11:0]       dec_word;
    logic              is_sel;
    logic              mapped;

    cosd_pkg::cosd_cfg_t cfg_reg  [NP];
    cosd_pkg::cosd_cfg_t cfg_next [NP];
    logic [1:0]          sel_reg;
    logic [1:0]          sel_next;
    logic [31:0]         prdata_reg;
    logic [31:0]         prdata_next;
    logic                slverr_reg;
    logic                slverr_next;
    logic [NP-1:0]       step_wr;

    // unit step for the tick counters, at counter width
    localparam logic [LW-1:0] ONE_LEN_L = cosd_pkg::ONE_LEN;

    cosd_pkg::cosd_path_t path_reg  [NP];
    cosd_pkg::cosd_path_t path_next [NP];
    logic [NP-1:0]        path_tick;

    // zero wait: data is registered in setup, write lands at access edge
    assign setup_phase = i_psel & ~i_penable;
    assign write_now   = i_psel & i_penable & i_pwrite;
    assign in_paths    = (i_paddr < cosd_pkg::PATH_SPAN);
    assign dec_path    = i_paddr[6:4];
    assign dec_word    = i_paddr & (cosd_pkg::PATH_STRIDE - 12'h001);
    assign is_sel      = (i_paddr == cosd_pkg::OFF_SRC_SEL);
    assign mapped      = in_paths | is_sel;
    assign o_pready    = 1'b1;
    assign o_prdata    = prdata_reg;
    assign o_pslverr   = slverr_reg;

    // register file next state; low bits of paddr are decoded, so unaligned offsets hit no register
    // read data is captured in setup so the access cycle needs no wait
    always_comb begin
        sel_next    = sel_reg;
        prdata_next = prdata_reg;
        slverr_next = 1'b0;
        step_wr     = '0;
        for (int p = 0; p < NP; p++) begin
            cfg_next[p] = cfg_reg[p];
        end

        // read side: unmapped addresses answer with an error and zero
        if (setup_phase) begin
            slverr_next = ~mapped;
            prdata_next = cosd_pkg::ZERO_WORD;
            if (is_sel) begin
                prdata_next[1:0] = sel_reg;
            end else if (in_paths) begin
                case (dec_word)
                    cosd_pkg::OFF_RATIO: begin
                        prdata_next = cfg_reg[dec_path].ratio;
                    end
                    cosd_pkg::OFF_HIGH: begin
                        prdata_next = cfg_reg[dec_path].high_width;
                    end
                    cosd_pkg::OFF_CTRL: begin
                        prdata_next[cosd_pkg::CTRL_INVERT]  = cfg_reg[dec_path].invert;
                        prdata_next[cosd_pkg::CTRL_PENDING] = path_reg[dec_path].pend;
                        prdata_next[cosd_pkg::CTRL_TRUE]    = path_reg[dec_path].true_out;
                        prdata_next[cosd_pkg::CTRL_COMP]    = path_reg[dec_path].comp_out;
                    end
                    cosd_pkg::OFF_PHASE: begin
                        prdata_next = path_reg[dec_path].step;
                    end
                    default: begin
                        prdata_next = cosd_pkg::ZERO_WORD;
                    end
                endcase
            end
        end

        // write side: lands at the access edge, unmapped writes dropped
        if (write_now) begin
            if (is_sel) begin
                sel_next = i_pwdata[1:0];
            end else if (in_paths) begin
                case (dec_word)
                    cosd_pkg::OFF_RATIO: begin
                        cfg_next[dec_path].ratio = i_pwdata;
                    end
                    cosd_pkg::OFF_HIGH: begin
                        cfg_next[dec_path].high_width = i_pwdata;
                    end
                    cosd_pkg::OFF_CTRL: begin
                        cfg_next[dec_path].invert = i_pwdata[cosd_pkg::CTRL_INVERT];
                    end
                    cosd_pkg::OFF_PHASE: begin
                        step_wr[dec_path] = 1'b1;
                    end
                    default: begin
                        step_wr = '0;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sel_reg    <= 2'h0;
            prdata_reg <= cosd_pkg::ZERO_WORD;
            slverr_reg <= 1'b0;
            for (int p = 0; p < NP; p++) begin
                cfg_reg[p].ratio      <= cosd_pkg::RATIO_RST;
                cfg_reg[p].high_width <= cosd_pkg::HIGH_RST;
                cfg_reg[p].invert     <= 1'b0;
            end
        end else begin
            sel_reg    <= sel_next;
            prdata_reg <= prdata_next;
            slverr_reg <= slverr_next;
            for (int p = 0; p < NP; p++) begin
                cfg_reg[p] <= cfg_next[p];
            end
        end
    end

    // apply a signed step to one half; shortening stops at the minimum, or keeps a half already below it
    function automatic logic [LW-1:0] step_half(input logic [LW-1:0] base,
                                                input logic signed [LW-1:0] d);
        logic signed [LW-1:0] sum;
        logic [LW-1:0]        res;
        sum = $signed(base) + d;
        res = sum;
        if (d < 0 && sum < $signed(cosd_pkg::MIN_HALF)) begin
            res = (base < cosd_pkg::MIN_HALF) ? base : cosd_pkg::MIN_HALF;
        end
        if (res == '0) begin
            res = cosd_pkg::ONE_LEN;
        end
        return res;
    endfunction

    // one generate body per path; paths 2s and 2s+1 share stage s's source
    for (genvar g = 0; g < NP; g++) begin : g_path
        localparam int unsigned STG = g / 2;
        logic                 src_tick;
        logic [LW-1:0]        ratio_x;
        logic [LW-1:0]        hw_x;
        logic [LW-1:0]        base_high;
        logic [LW-1:0]        base_low;
        logic signed [LW-1:0] adj;
        logic signed [LW-1:0] adj_high;
        logic signed [LW-1:0] adj_low;
        logic                 pulse_mode;

        // source divider select per stage
        // a select change mid-period only alters the tick rate, not the count
        always_comb begin
            case (STG)
                0: begin
                    src_tick = sel_reg[cosd_pkg::SEL_A_BIT] ?
                               i_frac_divider_tick[cosd_pkg::FRAC_FIVE] :
                               i_frac_divider_tick[cosd_pkg::FRAC_FOUR];
                end
                1: begin
                    src_tick = i_frac_divider_tick[cosd_pkg::FRAC_FIVE];
                end
                2: begin
                    src_tick = i_frac_divider_tick[cosd_pkg::FRAC_SIX];
                end
                3: begin
                    src_tick = sel_reg[cosd_pkg::SEL_B_BIT] ?
                               i_frac_divider_tick[cosd_pkg::FRAC_SEVEN] :
                               i_frac_divider_tick[cosd_pkg::FRAC_SIX];
                end
                default: begin
                    src_tick = 1'b0;
                end
            endcase
        end
        assign path_tick[g] = src_tick;

        // base halves from ratio and pulse width, zero width means 50/50
        assign ratio_x    = {2'b00, cfg_reg[g].ratio};
        assign hw_x       = {2'b00, cfg_reg[g].high_width};
        assign pulse_mode = (cfg_reg[g].high_width != cosd_pkg::ZERO_WORD);
        assign base_high  = pulse_mode ? hw_x : (ratio_x - (ratio_x >> 1));
        assign base_low   = pulse_mode ? (ratio_x - hw_x) : (ratio_x >> 1);
        // signed zero keeps the arms signed, so the shift stays arithmetic
        assign adj        = path_reg[g].pend ?
                            LW'($signed(path_reg[g].step)) :
                            $signed({LW{1'b0}});
        // pulse mode moves only the low time; 50/50 splits the step
        assign adj_high   = pulse_mode ? $signed({LW{1'b0}}) :
                            (adj >>> 1);
        assign adj_low    = adj - adj_high;

        // period engine: counts source ticks inside each half
        always_comb begin
            path_next[g] = path_reg[g];
            if (step_wr[g]) begin
                path_next[g].pend = 1'b1;
                path_next[g].step = i_pwdata;
            end
            if (src_tick) begin
                if (path_reg[g].level) begin
                    if (path_reg[g].cnt >= path_reg[g].high_len - ONE_LEN_L) begin
                        path_next[g].level = 1'b0;
                        path_next[g].cnt   = '0;
                    end else begin
                        path_next[g].cnt = path_reg[g].cnt + ONE_LEN_L;
                    end
                end else if (path_reg[g].cnt >= path_reg[g].low_len - ONE_LEN_L) begin
                    // new period: whole pending step lands here
                    path_next[g].level    = 1'b1;
                    path_next[g].cnt      = '0;
                    path_next[g].high_len = step_half(base_high, adj_high);
                    path_next[g].low_len  = step_half(base_low, adj_low);
                    // a write in this very cycle keeps its step pending
                    if (!step_wr[g]) begin
                        path_next[g].pend = 1'b0;
                    end
                end else begin
                    path_next[g].cnt = path_reg[g].cnt + ONE_LEN_L;
                end
            end
            path_next[g].true_out = path_next[g].level;
            path_next[g].comp_out = cfg_reg[g].invert ?
                                    ~path_next[g].level : path_next[g].level;
        end

        always_ff @(posedge i_clk or negedge i_arst_n) begin
            if (!i_arst_n) begin
                path_reg[g].level    <= 1'b0;
                path_reg[g].cnt      <= '0;
                path_reg[g].high_len <= cosd_pkg::ONE_LEN;
                path_reg[g].low_len  <= cosd_pkg::ONE_LEN;
                path_reg[g].pend     <= 1'b0;
                path_reg[g].step     <= cosd_pkg::ZERO_WORD;
                path_reg[g].true_out <= 1'b0;
                path_reg[g].comp_out <= 1'b0;
            end else begin
                path_reg[g] <= path_next[g];
            end
        end

        assign o_true_output_pin[g]          = path_reg[g].true_out;
        assign o_complementary_output_pin[g] = path_reg[g].comp_out;
    end

endmodule // cosd_output_stage

// >>> verilog/cosd_pkg.sv
package cosd_pkg;

    // stage and path counts: four stages, each built as a dual stage
    localparam int unsigned NUM_STAGES = 4;
    localparam int unsigned NUM_PATHS  = 8;
    localparam int unsigned NUM_FRAC   = 4;
    localparam int unsigned LEN_W      = 34;

    // fractional divider tick index (frac_divider_four .. frac_divider_seven)
    localparam logic [1:0] FRAC_FOUR  = 2'h0;
    localparam logic [1:0] FRAC_FIVE  = 2'h1;
    localparam logic [1:0] FRAC_SIX   = 2'h2;
    localparam logic [1:0] FRAC_SEVEN = 2'h3;

    // apb map: path p occupies a 16-byte block at p * 0x10
    localparam logic [11:0] PATH_STRIDE   = 12'h010;
    localparam logic [11:0] OFF_RATIO     = 12'h000;
    localparam logic [11:0] OFF_HIGH      = 12'h004;
    localparam logic [11:0] OFF_CTRL      = 12'h008;
    localparam logic [11:0] OFF_PHASE     = 12'h00C;
    localparam logic [11:0] OFF_SRC_SEL   = 12'h100;
    localparam logic [11:0] PATH_SPAN     = 12'h080;

    // control register fields
    localparam int unsigned CTRL_INVERT   = 0;
    localparam int unsigned CTRL_PENDING  = 8;
    localparam int unsigned CTRL_TRUE     = 9;
    localparam int unsigned CTRL_COMP     = 10;
    localparam int unsigned SEL_A_BIT     = 0;
    localparam int unsigned SEL_B_BIT     = 1;

    // reset values
    localparam logic [31:0] RATIO_RST     = 32'h0000_0002;
    localparam logic [31:0] HIGH_RST      = 32'h0000_0000;
    localparam logic [31:0] ZERO_WORD     = 32'h0000_0000;

    // minimum high and low time when a step shortens the period
    localparam logic [LEN_W-1:0] MIN_HALF = 34'h0_0000_0002;
    localparam logic [LEN_W-1:0] ONE_LEN  = 34'h0_0000_0001;

    typedef struct packed {
        logic [31:0] ratio;
        logic [31:0] high_width;
        logic        invert;
    } cosd_cfg_t;

    typedef struct packed {
        logic             level;
        logic [LEN_W-1:0] cnt;
        logic [LEN_W-1:0] high_len;
        logic [LEN_W-1:0] low_len;
        logic             pend;
        logic [31:0]      step;
        logic             true_out;
        logic             comp_out;
    } cosd_path_t;

endpackage : cosd_pkg
